// file: rtl/xpc_exec.sv
// execution of add-to-pointer, add-frame-and-return and call via w
// assumes decode presents one instruction per cycle on instr_valid,
// same clock, and holds off while busy_q is high
//
// How it works
// - add 6-bit literal to chosen pointer, one cycle
// - select 11 means frame variant on pointer two
// - frame variant then loads pc from stack top
// - frame variant takes two cycles, second idle
// - computed call pushes pc plus two first, unless sp_q is at SP_FULL
// - working register replaces pc low byte
// - latches fill pc high byte and upper five bits
// - computed call is two cycles, second idle
// - computed call saves no shadow registers
// - decode only while extended set bit is set
`timescale 1ns/10ps
module xpc_exec (
  input  wire logic                               clk,
  input  wire logic                               arst_n,
  input  wire logic                               ce,
  input  wire logic                               ext_set_pin,
  input  wire logic                               instr_valid,
  input  wire logic [15:0]                        instr,
  input  wire logic [xpc_pkg::PC_W-1:0]           pc_in,
  input  wire logic [7:0]                         working_register,
  input  wire logic [7:0]                         pc_high_latch,
  input  wire logic [7:0]                         pc_upper_latch,
  input  wire logic                               ptr_wr_en,
  input  wire logic [1:0]                         ptr_wr_sel,
  input  wire logic [xpc_pkg::PTR_W-1:0]          ptr_wr_data,
  output logic [xpc_pkg::PTR_N-1:0][xpc_pkg::PTR_W-1:0] ptrs_q,
  output logic [xpc_pkg::PC_W-1:0]                pc_q,
  output logic                                    pc_load_q,
  output logic                                    busy_q,
  output logic                                    handled_q,
  output logic [xpc_pkg::STK_AW-1:0]              sp_q,
  output logic [xpc_pkg::PC_W-1:0]                top_of_return_stack
);
  //////////////////////////////////////////////////////////////////////
  // config bit synchroniser
  logic ext_meta_q;
  logic ext_en_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ext_meta_q <= 1'b0;
      ext_en_q   <= 1'b0;
    end else if (ce) begin
      ext_meta_q <= ext_set_pin;
      ext_en_q   <= ext_meta_q;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // decode
  function automatic logic is_addptr(input logic [15:0] w);
    return w[15:xpc_pkg::OP_LSB] == xpc_pkg::OP_ADDPTR;
  endfunction

  function automatic logic is_call_via_working_reg(input logic [15:0] w);
    return w == xpc_pkg::OP_CALL_VIA_WORKING_REG;
  endfunction

  xpc_pkg::xpc_state_t state_q;
  logic       take;
  logic       do_add;
  logic       do_ret;
  logic       do_call;
  logic [1:0] sel;
  logic [1:0] tgt;
  logic [xpc_pkg::PTR_W-1:0] lit;

  assign take    = ce && instr_valid && ext_en_q
                   && (state_q == xpc_pkg::ST_RUN);
  assign sel     = instr[xpc_pkg::SEL_LSB +: 2];
  assign lit     = {{(xpc_pkg::PTR_W-xpc_pkg::LIT_W){1'b0}},
                    instr[xpc_pkg::LIT_LSB +: xpc_pkg::LIT_W]};
  assign do_add  = take && is_addptr(instr);
  assign do_ret  = do_add && (sel == xpc_pkg::SEL_FRAME);
  assign do_call = take && is_call_via_working_reg(instr);
  assign tgt     = do_ret ? xpc_pkg::FRAME_IDX : sel;

  //////////////////////////////////////////////////////////////////////
  // sequencing of the idle second cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= xpc_pkg::ST_RUN;
    end else if (ce) begin
      unique case (state_q)
        xpc_pkg::ST_RUN: begin
          if (do_ret || do_call) begin
            state_q <= xpc_pkg::ST_NOP;
          end
        end
        xpc_pkg::ST_NOP: begin
          state_q <= xpc_pkg::ST_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_q    <= 1'b0;
      handled_q <= 1'b0;
    end else if (ce) begin
      busy_q    <= do_ret || do_call;
      handled_q <= do_add || do_call;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // pointer registers
  for (genvar g = 0; g < xpc_pkg::PTR_N; g++) begin : g_ptr
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        ptrs_q[g] <= xpc_pkg::PTR_RST;
      end else if (ce) begin
        if (do_add && (tgt == 2'(g))) begin
          ptrs_q[g] <= ptrs_q[g] + lit;
        end else if (ptr_wr_en && (ptr_wr_sel == 2'(g))) begin
          ptrs_q[g] <= ptr_wr_data;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // return stack and program counter
  logic [xpc_pkg::PC_W-1:0]   stk_rd;
  logic [xpc_pkg::STK_AW-1:0] rd_addr;
  logic                       push;

  assign push    = do_call && (sp_q != xpc_pkg::SP_FULL);
  assign rd_addr = sp_q - xpc_pkg::SP_ONE;
  assign top_of_return_stack = stk_rd;

  xpc_ret_stack u_stack (
    .clk     (clk),
    .ce      (ce),
    .wr_en   (push),
    .wr_addr (sp_q),
    .wr_data (pc_in + xpc_pkg::RET_OFS),
    .rd_addr (rd_addr),
    .rd_q    (stk_rd)
  );

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sp_q <= xpc_pkg::SP_EMPTY;
    end else if (ce) begin
      if (push) begin
        sp_q <= sp_q + xpc_pkg::SP_ONE;
      end else if (do_ret && (sp_q != xpc_pkg::SP_EMPTY)) begin
        sp_q <= sp_q - xpc_pkg::SP_ONE;
      end
    end
  end

  // the call touches only pc and stack; w, status and bank stay put
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pc_q      <= xpc_pkg::PC_RST;
      pc_load_q <= 1'b0;
    end else if (ce) begin
      pc_load_q <= do_ret || do_call;
      if (do_ret) begin
        pc_q <= stk_rd;
      end else if (do_call) begin
        pc_q <= {pc_upper_latch[4:0], pc_high_latch,
                 working_register};
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // checks
  sequence s_call_taken;
    do_call;
  endsequence

  sequence s_idle_then_run;
    busy_q ##1 1'b1;
  endsequence

  chk_add_pointer: assert property (
    @(posedge clk) disable iff (!arst_n)
    (do_add && !do_ret && !ptr_wr_en) |=>
      ptrs_q[$past(sel)] == $past(ptrs_q[sel]) + $past(lit))
    else $error("pointer add result wrong");

  chk_frame_only_two: assert property (
    @(posedge clk) disable iff (!arst_n)
    (do_ret && !ptr_wr_en) |=>
      ptrs_q[0] == $past(ptrs_q[0]) && ptrs_q[1] == $past(ptrs_q[1])
      && ptrs_q[2] == $past(ptrs_q[2]) + $past(lit))
    else $error("frame variant touched wrong pointer");

  chk_ret_pc: assert property (
    @(posedge clk) disable iff (!arst_n)
    do_ret |=> pc_load_q && pc_q == $past(stk_rd))
    else $error("return did not load stack top");

  chk_ret_two_cycles: assert property (
    @(posedge clk) disable iff (!arst_n)
    do_ret |=> busy_q && !take)
    else $error("frame return lacks idle cycle");

  chk_call_push: assert property (
    @(posedge clk) disable iff (!arst_n)
    (s_call_taken and (sp_q != xpc_pkg::SP_FULL)) |=>
      sp_q == $past(sp_q) + xpc_pkg::SP_ONE)
    else $error("call did not push");

  chk_call_target: assert property (
    @(posedge clk) disable iff (!arst_n)
    s_call_taken |=> pc_q == {$past(pc_upper_latch[4:0]),
      $past(pc_high_latch), $past(working_register)})
    else $error("call target wrong");

  chk_call_idle: assert property (
    @(posedge clk) disable iff (!arst_n)
    (s_call_taken ##1 ce) |-> s_idle_then_run ##0 !busy_q)
    else $error("call idle cycle wrong");

  chk_call_no_ptr: assert property (
    @(posedge clk) disable iff (!arst_n)
    (s_call_taken and !ptr_wr_en) |=> ptrs_q == $past(ptrs_q))
    else $error("call changed pointers");

  chk_disabled_idle: assert property (
    @(posedge clk) disable iff (!arst_n)
    (!ext_en_q && !ptr_wr_en && ce) |=>
      !pc_load_q && ptrs_q == $past(ptrs_q))
    else $error("extended op ran while disabled");

  chk_ptr_wrap: assert property (
    @(posedge clk) disable iff (!arst_n)
    (do_add && !do_ret && !ptr_wr_en
     && ptrs_q[sel] + lit < ptrs_q[sel]) |=>
      ptrs_q[$past(sel)] < $past(ptrs_q[sel]))
    else $error("pointer did not wrap");
endmodule

// file: rtl/xpc_pkg.sv
// constants for the extended pointer and computed call execution block
// assumes a single core clock with four phases folded into one edge
package xpc_pkg;
  localparam int          PTR_W      = 12;
  localparam int          PTR_N      = 3;
  localparam int          PC_W       = 21;
  localparam int          STK_DEPTH  = 31;
  localparam int          STK_AW     = 5;
  localparam int          LIT_W      = 6;
  localparam logic [7:0]  OP_ADDPTR  = 8'he8;
  localparam logic [15:0] OP_CALL_VIA_WORKING_REG   = 16'h0014;
  localparam logic [1:0]  SEL_FRAME  = 2'h3;
  localparam logic [1:0]  FRAME_IDX  = 2'h2;
  localparam logic [PC_W-1:0]   RET_OFS  = 21'h000002;
  localparam logic [PC_W-1:0]   PC_RST   = 21'h000000;
  localparam logic [PTR_W-1:0]  PTR_RST  = 12'h000;
  localparam logic [STK_AW-1:0] SP_EMPTY = 5'h00;
  localparam logic [STK_AW-1:0] SP_FULL  = 5'h1f;
  localparam logic [STK_AW-1:0] SP_ONE   = 5'h01;
  localparam logic [7:0]  SEL_HI     = 8'h0f;
  localparam int          LIT_LSB    = 0;
  localparam int          SEL_LSB    = 6;
  localparam int          OP_LSB     = 8;
  typedef enum logic [0:0] {ST_RUN, ST_NOP} xpc_state_t;
endpackage

// file: rtl/xpc_ret_stack.sv
// hardware return stack storage, one write port and one read port
// assumes the caller keeps the pointer; read data is registered
`timescale 1ns/10ps
module xpc_ret_stack (
  input  wire logic                          clk,
  input  wire logic                          ce,
  input  wire logic                          wr_en,
  input  wire logic [xpc_pkg::STK_AW-1:0]    wr_addr,
  input  wire logic [xpc_pkg::PC_W-1:0]      wr_data,
  input  wire logic [xpc_pkg::STK_AW-1:0]    rd_addr,
  output logic      [xpc_pkg::PC_W-1:0]      rd_q
);
  logic [xpc_pkg::PC_W-1:0] mem [xpc_pkg::STK_DEPTH+1];

  always_ff @(posedge clk) begin
    if (ce && wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (ce) begin
      rd_q <= mem[rd_addr];
    end
  end
endmodule

// file: tb/tb_xpc_exec.sv
// bench for the extended pointer and computed call execution block
// assumes rtl/xpc_pkg.sv and the design modules are compiled first
`timescale 1ns/10ps
module tb_xpc_exec;
  logic                                          clk;
  logic                                          arst_n;
  logic                                          ce;
  logic                                          ext_set_pin;
  logic                                          instr_valid;
  logic [15:0]                                   instr;
  logic [xpc_pkg::PC_W-1:0]                      pc_in;
  logic [7:0]                                    working_register;
  logic [7:0]                                    pc_high_latch;
  logic [7:0]                                    pc_upper_latch;
  logic                                          ptr_wr_en;
  logic [1:0]                                    ptr_wr_sel;
  logic [xpc_pkg::PTR_W-1:0]                     ptr_wr_data;
  logic [xpc_pkg::PTR_N-1:0][xpc_pkg::PTR_W-1:0] ptrs_q;
  logic [xpc_pkg::PC_W-1:0]                      pc_q;
  logic                                          pc_load_q;
  logic                                          busy_q;
  logic                                          handled_q;
  logic [xpc_pkg::STK_AW-1:0]                    sp_q;
  logic [xpc_pkg::PC_W-1:0]                      top_of_return_stack;
  int                                            error_cnt;
  int                                            n_tests;
  int                                            cyc;

  xpc_exec xpc_exec_inst (.clk(clk), .arst_n(arst_n), .ce(ce),
    .ext_set_pin(ext_set_pin), .instr_valid(instr_valid), .instr(instr),
    .pc_in(pc_in), .working_register(working_register),
    .pc_high_latch(pc_high_latch), .pc_upper_latch(pc_upper_latch),
    .ptr_wr_en(ptr_wr_en), .ptr_wr_sel(ptr_wr_sel),
    .ptr_wr_data(ptr_wr_data), .ptrs_q(ptrs_q), .pc_q(pc_q),
    .pc_load_q(pc_load_q), .busy_q(busy_q), .handled_q(handled_q),
    .sp_q(sp_q), .top_of_return_stack(top_of_return_stack));

  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      error_cnt = error_cnt + 1;
      conclude();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      error_cnt = error_cnt + 1;
      $display("Error at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // present one op for a single cycle, return at the answer cycle
  task automatic issue(input logic [15:0] op, input logic [20:0] pc);
    @(negedge clk);
    instr = op;
    pc_in = pc;
    instr_valid = 1'b1;
    @(negedge clk);
    instr_valid = 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_ext_off;
    issue(16'he805, 21'h000010);
    chk(ptrs_q[0], 12'h000);
    chk(handled_q, 1'b0);
    ext_set_pin = 1'b1;
    repeat (3) @(negedge clk);
  endtask

  task automatic t_add_b2b;
    int i;
    @(negedge clk);
    instr_valid = 1'b1;
    for (i = 0; i < 3; i++) begin
      instr = {8'he8, i[1:0], 6'h3f};
      @(negedge clk);
      chk(ptrs_q[i], 12'h03f);
      chk({handled_q, busy_q, pc_load_q}, 3'h4);
    end
    instr_valid = 1'b0;
    ptr_wr_en = 1'b1;
    ptr_wr_sel = 2'h2;
    ptr_wr_data = 12'hfff;
    @(negedge clk);
    ptr_wr_en = 1'b0;
    issue({8'he8, 2'h2, 6'h03}, 21'h000020);
    chk(ptrs_q[2], 12'h002);
    chk(ptrs_q[1], 12'h03f);
  endtask

  task automatic t_call;
    working_register = 8'h06;
    pc_high_latch = 8'h10;
    pc_upper_latch = 8'hfa;
    issue(16'h0014, 21'h000100);
    chk(pc_q, 21'h1a1006);
    chk(pc_q[20:8], 13'h1a10);
    chk({pc_load_q, busy_q}, 2'h3);
    chk(sp_q, 5'h01);
    chk(ptrs_q[2], 12'h002);
    @(negedge clk);
    chk({pc_load_q, busy_q}, 2'h0);
    @(negedge clk);
    chk(top_of_return_stack, 21'h000102);
  endtask

  task automatic t_frame_ret;
    issue({8'he8, 2'h3, 6'h21}, 21'h001006);
    chk(ptrs_q[2], 12'h023);
    chk({ptrs_q[1], ptrs_q[0]}, 24'h03f03f);
    chk(pc_q, 21'h000102);
    chk(sp_q, 5'h00);
    chk({pc_load_q, busy_q}, 2'h3);
    @(negedge clk);
    chk({pc_load_q, busy_q}, 2'h0);
    chk(ptrs_q[2], 12'h023);
  endtask

  // op held over the idle cycle, frozen clock, add against direct write
  task automatic t_refused;
    working_register = 8'h40;
    pc_high_latch = 8'h22;
    pc_upper_latch = 8'h01;
    @(negedge clk);
    instr = 16'h0014;
    pc_in = 21'h000200;
    instr_valid = 1'b1;
    @(negedge clk);
    instr = 16'he805;
    chk(pc_q, 21'h012240);
    @(negedge clk);
    chk(sp_q, 5'h01);
    chk(ptrs_q[0], 12'h03f);
    chk(handled_q, 1'b0);
    ce = 1'b0;
    instr = 16'he80a;
    @(negedge clk);
    chk(ptrs_q[0], 12'h03f);
    chk(handled_q, 1'b0);
    ce = 1'b1;
    ptr_wr_en = 1'b1;
    ptr_wr_sel = 2'h0;
    ptr_wr_data = 12'h123;
    @(negedge clk);
    instr_valid = 1'b0;
    ptr_wr_en = 1'b0;
    chk(ptrs_q[0], 12'h049);
    chk(handled_q, 1'b1);
    chk(top_of_return_stack, 21'h000202);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    error_cnt = 0;
    n_tests = 0;
    cyc = 0;
    arst_n = 1'b0;
    ce = 1'b1;
    ext_set_pin = 1'b0;
    instr_valid = 1'b0;
    instr = 16'h0000;
    pc_in = 21'h000000;
    working_register = 8'h00;
    pc_high_latch = 8'h00;
    pc_upper_latch = 8'h00;
    ptr_wr_en = 1'b0;
    ptr_wr_sel = 2'h0;
    ptr_wr_data = 12'h000;
    repeat (5) @(negedge clk);
    arst_n = 1'b1;
    repeat (3) @(negedge clk);
    t_ext_off();
    t_add_b2b();
    t_call();
    t_frame_ret();
    t_refused();
    conclude();
  end
endmodule
